// >>> src/conv_cfg_pkg.sv
// Package with register map, field positions and timing counts
package conv_cfg_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // Word offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_CTRL   = 8'h50;
  localparam logic [7:0] IDX_BOOST_ADJ   = 8'h51;
  localparam logic [7:0] IDX_TIMING      = 8'h52;
  localparam logic [7:0] IDX_REG_B       = 8'h53;
  localparam logic [7:0] IDX_REG_C       = 8'h54;
  localparam logic [7:0] IDX_SEQ_ONTIME  = 8'h55;
  localparam logic [7:0] IDX_BUCK_PROT   = 8'h56;
  localparam logic [7:0] IDX_BUCK_MODE   = 8'h57;
  localparam logic [7:0] IDX_ENV_CTRL    = 8'h60;
  localparam logic [7:0] IDX_STATUS      = 8'h61;

  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] BUCK_PROT_MASK  = 8'h03;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  // Field positions
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned SPEED_LSB      = 6;
  localparam int unsigned ADJ_LSB        = 0;
  localparam int unsigned NOADJ_BIT      = 7;
  localparam int unsigned SWFAST_BIT     = 6;
  localparam int unsigned INRUSH_A_LSB   = 2;
  localparam int unsigned TOFF_LSB       = 0;
  localparam int unsigned NOAUTO_BIT     = 7;
  localparam int unsigned BYPASS_BIT     = 6;
  localparam int unsigned VMIN_LSB       = 4;
  localparam int unsigned GAIN_LSB       = 0;
  localparam int unsigned STANDALONE_BIT = 7;
  localparam int unsigned SEQ_FIRST_BIT  = 7;
  localparam int unsigned TON_A_LSB      = 4;
  localparam int unsigned INRUSH_C_LSB   = 0;
  localparam int unsigned OVP_OFF_BIT    = 1;
  localparam int unsigned CLAMP_BIT      = 0;
  localparam int unsigned TON_B_LSB      = 5;

  // Timing figures in nanoseconds at a 100 ns core clock
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned INRUSH_UNIT_NS = 300;
  localparam int unsigned TON_UNIT_NS    = 70;
  localparam int unsigned TOFF_1_NS      = 900;
  localparam int unsigned TOFF_2_NS      = 1500;
  localparam int unsigned TOFF_3_NS      = 2100;
  // Longest times round down, least times round up, floor of one cycle
  localparam int unsigned TOFF_1_CYC     = TOFF_1_NS / CLK_PERIOD_NS;
  localparam int unsigned TOFF_2_CYC     = TOFF_2_NS / CLK_PERIOD_NS;
  localparam int unsigned TOFF_3_CYC     = TOFF_3_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_DISABLED    = 3'h0,
    MODE_AUTONOMOUS  = 3'h1,
    MODE_FORCE_BUCK  = 3'h2,
    MODE_FORCE_NEAR  = 3'h3,
    MODE_FORCE_BOOST = 3'h4,
    MODE_WIRED_BUCK_FALLBACK = 3'h5,
    MODE_WIRED_BUCK  = 3'h6,
    MODE_WIRED_BOOST = 3'h7
  } conv_mode_t;

  typedef enum logic [1:0] {
    ES_RUN      = 2'h0,
    ES_LOW_POWER = 2'h1,
    ES_SHUTOFF  = 2'h3
  } energy_state_t;

  // Operating stage of converter one
  typedef enum logic [1:0] {
    OP_OFF    = 2'b00,
    OP_BUCK   = 2'b01,
    OP_NEAR   = 2'b11,
    OP_BOOST  = 2'b10
  } conv_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic              bypass_only;
    logic              auto_bypass_en;
    logic [1:0]        min_voltage;
    logic [3:0]        current_gain;
    logic [4:0]        gain_divisor;
  } ldo_cfg_t;

endpackage : conv_cfg_pkg

// >>> src/cycle_limit.sv
// Cycle count limit from a multiplier field: unit * (k*n + 1)
`timescale 1ns/1ns
`default_nettype none
module cycle_limit #(
  parameter int unsigned FIELD_W = 4,
  parameter int unsigned STEP    = 2,
  parameter int unsigned UNIT_NS = 300,
  parameter int unsigned ROUND_UP = 1,
  parameter int unsigned OUT_W   = 12
) (
  input  wire logic [FIELD_W-1:0] field_in,
  output logic                    bounded_out,
  output logic [OUT_W-1:0]        cycles_out
);
  localparam int unsigned PER = conv_cfg_pkg::CLK_PERIOD_NS;
  logic [31:0] time_ns;
  logic [31:0] cyc;
  assign time_ns = UNIT_NS * (STEP * {{(32-FIELD_W){1'b0}}, field_in} + 1);
  assign cyc     = (ROUND_UP != 0) ? (time_ns + PER - 1) / PER
                                   : time_ns / PER;
  assign bounded_out = (field_in != '0);
  assign cycles_out  = (cyc == 32'd0) ? OUT_W'(1) : cyc[OUT_W-1:0];
endmodule : cycle_limit
`default_nettype wire

// >>> src/ldo_decode.sv
// Linear regulator field decode
`timescale 1ns/1ns
`default_nettype none
module ldo_decode (
  input  wire logic [7:0]           ctrl_in,
  input  wire logic                 no_auto_bypass_in,
  output conv_cfg_pkg::ldo_cfg_t    cfg_out
);
  logic [3:0] gain;
  assign gain = ctrl_in[conv_cfg_pkg::GAIN_LSB +: 4];
  assign cfg_out.bypass_only    = ctrl_in[conv_cfg_pkg::BYPASS_BIT];
  assign cfg_out.auto_bypass_en = ~no_auto_bypass_in;
  assign cfg_out.min_voltage    = ctrl_in[conv_cfg_pkg::VMIN_LSB +: 2];
  assign cfg_out.current_gain   = gain;
  // Current scales as 1/(17 - gain)
  assign cfg_out.gain_divisor   = 5'd17 - {1'b0, gain};
endmodule : ldo_decode
`default_nettype wire

// >>> src/regulator_converter_config_bank.sv
// Converter and regulator configuration bank with Avalon-MM slave
// Operation
// - Mode field decodes disabled, autonomous, forced and wired modes.
// - Wired buck fallback switches to regulator when input too low.
// - Bits 7:6 of boost adjust set pre-driver speed; 2 recommended.
// - Boost adjust value steers compensation only when no-adjust is 0.
// - Timing bit 7 clear raises boost peak current as battery falls.
// - Low-power state always suppresses boost peak-current adjustment.
// - Bit 6 selects high-speed switched-output driver.
// - Inrush field n sets minimum period 300ns*(2n+1); zero unbounded.
// - Off-time limit decodes none, 0.9, 1.5 and 2.1 us.
// - Regulator-B bit 7 blocks automatic bypass of both regulators.
// - Regulator-B bit 6 makes regulator B a pure bypass switch.
// - Gain field scales maximum current by 1/(17 - value).
// - Regulator-C bit 7 standalone enable, forced off in shutoff.
// - Regulator-C bit 6 shorts input to output as bypass.
// - Sequencing bit holds buck and C until converter one regulates.
// - On-time field caps at 70ns*(4n+1); zero unbounded.
// - Regulator-C inrush field n gives 300ns*(2n+1) minimum period.
// - Buck protect bit 1 disables overvoltage pull-down.
// - Buck protect bit 0 enables clamp only in shutoff state.
// - Buck on-time field caps at 70ns*(4n+1); zero unbounded.
// - Mode field at 0x50 bits 2:0; disabled in shutoff state.
`timescale 1ns/1ns
`default_nettype none
module regulator_converter_config_bank #(
  parameter int unsigned CYC_W = 12
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic [7:0]              avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic [31:0]                  avs_readdata_out,
  output logic                         avs_waitrequest_out,
  input  wire logic [1:0]              energy_state_in,
  input  wire logic                    input_too_low_in,
  input  wire logic                    conv_one_in_regulation_in,
  output logic [1:0]                   conv_one_op_out,
  output logic                         conv_one_fallback_ldo_out,
  output logic [1:0]                   converter_one_predriver_speed_out,
  output logic                         boost_comp_active_out,
  output logic [5:0]                   boost_peak_comp_value_out,
  output logic                         switched_output_highspeed_out,
  output logic                         inrush_a_bounded_out,
  output logic [CYC_W-1:0]             inrush_a_cycles_out,
  output logic                         offtime_bounded_out,
  output logic [CYC_W-1:0]             offtime_cycles_out,
  output logic                         ontime_a_bounded_out,
  output logic [CYC_W-1:0]             ontime_a_cycles_out,
  output logic                         inrush_c_bounded_out,
  output logic [CYC_W-1:0]             inrush_c_cycles_out,
  output conv_cfg_pkg::ldo_cfg_t       regulator_b_cfg_out,
  output conv_cfg_pkg::ldo_cfg_t       regulator_c_cfg_out,
  output logic                         regulator_c_enable_out,
  output logic                         buck_enable_allowed_out,
  output logic                         buck_overvoltage_pulldown_out,
  output logic                         buck_output_shutoff_pulldown_out,
  output logic                         buck_ontime_bounded_out,
  output logic [CYC_W-1:0]             buck_ontime_cycles_out
);

  // Register storage
  logic [7:0] mode_reg;
  logic [7:0] boost_adjust_ctrl_reg;
  logic [7:0] converter_a_timing_ctrl_reg;
  logic [7:0] regulator_b_ctrl_reg;
  logic [7:0] regulator_c_ctrl_reg;
  logic [7:0] sequencing_ontime_ctrl_reg;
  logic [7:0] buck_protect_ctrl_reg;
  logic [7:0] buck_mode_ctrl_reg;
  logic [7:0] env_ctrl_reg;
  logic       ack_reg;

  conv_cfg_pkg::av_req_t req;
  assign req.address   = avs_address_in;
  assign req.read      = avs_read_in;
  assign req.write     = avs_write_in;
  assign req.writedata = avs_writedata_in;

  // One wait cycle per access; answer on the second edge
  wire        access   = (req.read | req.write) & ~ack_reg;
  wire        wr_fire  = req.write & ack_reg;
  wire        lane0    = avs_byteenable_in[0];
  wire [7:0]  wbyte    = req.writedata[7:0];
  wire        wr_mode  = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_MODE_CTRL);
  wire        wr_badj  = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_BOOST_ADJ);
  wire        wr_tim   = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_TIMING);
  wire        wr_regb  = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_REG_B);
  wire        wr_regc  = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_REG_C);
  wire        wr_seq   = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_SEQ_ONTIME);
  wire        wr_prot  = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_BUCK_PROT);
  wire        wr_bmode = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_BUCK_MODE);
  wire        wr_env   = wr_fire & lane0 &
                         (req.address == conv_cfg_pkg::IDX_ENV_CTRL);

  // Energy state and mode decode
  wire shutoff   = (energy_state_in == conv_cfg_pkg::ES_SHUTOFF);
  wire low_power = (energy_state_in == conv_cfg_pkg::ES_LOW_POWER);
  conv_cfg_pkg::conv_mode_t mode;
  assign mode = conv_cfg_pkg::conv_mode_t'(
                  mode_reg[conv_cfg_pkg::MODE_LSB +: 3]);

  // Autonomous mode picks the stage from a simple input-level view
  logic [1:0] op_next;
  always_comb
  begin
    op_next = conv_cfg_pkg::OP_OFF;
    if (!shutoff)
    begin
      case (mode)
        conv_cfg_pkg::MODE_DISABLED:    op_next = conv_cfg_pkg::OP_OFF;
        conv_cfg_pkg::MODE_AUTONOMOUS:
          op_next = input_too_low_in ? conv_cfg_pkg::OP_BOOST
                                     : conv_cfg_pkg::OP_BUCK;
        conv_cfg_pkg::MODE_FORCE_BUCK:  op_next = conv_cfg_pkg::OP_BUCK;
        conv_cfg_pkg::MODE_FORCE_NEAR:  op_next = conv_cfg_pkg::OP_NEAR;
        conv_cfg_pkg::MODE_FORCE_BOOST: op_next = conv_cfg_pkg::OP_BOOST;
        conv_cfg_pkg::MODE_WIRED_BUCK_FALLBACK:
          op_next = input_too_low_in ? conv_cfg_pkg::OP_OFF
                                     : conv_cfg_pkg::OP_BUCK;
        conv_cfg_pkg::MODE_WIRED_BUCK:  op_next = conv_cfg_pkg::OP_BUCK;
        conv_cfg_pkg::MODE_WIRED_BOOST: op_next = conv_cfg_pkg::OP_BOOST;
        default:                        op_next = conv_cfg_pkg::OP_OFF;
      endcase
    end
  end

  wire fallback_next = ~shutoff &
       (mode == conv_cfg_pkg::MODE_WIRED_BUCK_FALLBACK) &
       input_too_low_in;

  wire boost_like = (op_next == conv_cfg_pkg::OP_BOOST);
  wire noadj      = converter_a_timing_ctrl_reg[conv_cfg_pkg::NOADJ_BIT];
  // Compensation only outside low-power and shutoff with adjustment allowed
  wire comp_next  = boost_like & ~noadj &
                    ~low_power & ~shutoff;

  // Regulator C enable with sequencing hold-off
  wire seq_hold   = sequencing_ontime_ctrl_reg[conv_cfg_pkg::SEQ_FIRST_BIT] &
                    ~conv_one_in_regulation_in;
  wire regc_next  = regulator_c_ctrl_reg[conv_cfg_pkg::STANDALONE_BIT] &
                    ~shutoff & ~seq_hold;
  wire buck_next  = ~shutoff & ~seq_hold;

  // Buck protection decode
  wire ovp_next   = ~buck_protect_ctrl_reg[conv_cfg_pkg::OVP_OFF_BIT];
  wire clamp_next = buck_protect_ctrl_reg[conv_cfg_pkg::CLAMP_BIT] &
                    shutoff;

  // Off-time limit table
  logic [CYC_W-1:0] toff_next;
  always_comb
  begin
    case (converter_a_timing_ctrl_reg[conv_cfg_pkg::TOFF_LSB +: 2])
      2'd1:    toff_next = CYC_W'(conv_cfg_pkg::TOFF_1_CYC);
      2'd2:    toff_next = CYC_W'(conv_cfg_pkg::TOFF_2_CYC);
      2'd3:    toff_next = CYC_W'(conv_cfg_pkg::TOFF_3_CYC);
      default: toff_next = '0;
    endcase
  end
  wire toff_bnd_next = (converter_a_timing_ctrl_reg[1:0] != 2'd0);

  // Limit counts, registered below
  logic             ia_bnd, ta_bnd, ic_bnd, tb_bnd;
  logic [CYC_W-1:0] ia_cyc, ta_cyc, ic_cyc, tb_cyc;

  cycle_limit #(.FIELD_W(4), .STEP(2),
    .UNIT_NS(conv_cfg_pkg::INRUSH_UNIT_NS), .ROUND_UP(1), .OUT_W(CYC_W))
  u_inrush_a (
    .field_in    (converter_a_timing_ctrl_reg[conv_cfg_pkg::INRUSH_A_LSB+:4]),
    .bounded_out (ia_bnd),
    .cycles_out  (ia_cyc)
  );

  cycle_limit #(.FIELD_W(3), .STEP(4),
    .UNIT_NS(conv_cfg_pkg::TON_UNIT_NS), .ROUND_UP(0), .OUT_W(CYC_W))
  u_ontime_a (
    .field_in    (sequencing_ontime_ctrl_reg[conv_cfg_pkg::TON_A_LSB +: 3]),
    .bounded_out (ta_bnd),
    .cycles_out  (ta_cyc)
  );

  cycle_limit #(.FIELD_W(4), .STEP(2),
    .UNIT_NS(conv_cfg_pkg::INRUSH_UNIT_NS), .ROUND_UP(1), .OUT_W(CYC_W))
  u_inrush_c (
    .field_in    (sequencing_ontime_ctrl_reg[conv_cfg_pkg::INRUSH_C_LSB +: 4]),
    .bounded_out (ic_bnd),
    .cycles_out  (ic_cyc)
  );

  cycle_limit #(.FIELD_W(3), .STEP(4),
    .UNIT_NS(conv_cfg_pkg::TON_UNIT_NS), .ROUND_UP(0), .OUT_W(CYC_W))
  u_ontime_b (
    .field_in    (buck_mode_ctrl_reg[conv_cfg_pkg::TON_B_LSB +: 3]),
    .bounded_out (tb_bnd),
    .cycles_out  (tb_cyc)
  );

  conv_cfg_pkg::ldo_cfg_t regb_cfg, regc_cfg;
  wire no_auto = regulator_b_ctrl_reg[conv_cfg_pkg::NOAUTO_BIT];

  ldo_decode u_regb (
    .ctrl_in           (regulator_b_ctrl_reg),
    .no_auto_bypass_in (no_auto),
    .cfg_out           (regb_cfg)
  );

  ldo_decode u_regc (
    .ctrl_in           (regulator_c_ctrl_reg),
    .no_auto_bypass_in (no_auto),
    .cfg_out           (regc_cfg)
  );

  // Status view of the block's own decode
  wire [7:0] status_byte = {1'b0, regulator_c_enable_out,
                            buck_enable_allowed_out, boost_comp_active_out,
                            conv_one_fallback_ldo_out, 1'b0,
                            conv_one_op_out};

  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (req.address)
      conv_cfg_pkg::IDX_MODE_CTRL:  rd_byte = mode_reg;
      conv_cfg_pkg::IDX_BOOST_ADJ:  rd_byte = boost_adjust_ctrl_reg;
      conv_cfg_pkg::IDX_TIMING:     rd_byte = converter_a_timing_ctrl_reg;
      conv_cfg_pkg::IDX_REG_B:      rd_byte = regulator_b_ctrl_reg;
      conv_cfg_pkg::IDX_REG_C:      rd_byte = regulator_c_ctrl_reg;
      conv_cfg_pkg::IDX_SEQ_ONTIME: rd_byte = sequencing_ontime_ctrl_reg;
      conv_cfg_pkg::IDX_BUCK_PROT:  rd_byte = buck_protect_ctrl_reg;
      conv_cfg_pkg::IDX_BUCK_MODE:  rd_byte = buck_mode_ctrl_reg;
      conv_cfg_pkg::IDX_ENV_CTRL:   rd_byte = env_ctrl_reg;
      conv_cfg_pkg::IDX_STATUS:     rd_byte = status_byte;
      default:
      begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end
  wire [31:0] rd_word = rd_hit ? {24'h00_0000, rd_byte}
                               : conv_cfg_pkg::UNMAPPED_DATA;

  // Bus handshake
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      ack_reg             <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      ack_reg             <= access;
      avs_waitrequest_out <= ~access;
      avs_readdata_out    <= (access & req.read) ? rd_word : 32'h0000_0000;
    end
  end

  // Register writes
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_reg                    <= conv_cfg_pkg::REG_RESET;
      boost_adjust_ctrl_reg       <= conv_cfg_pkg::REG_RESET;
      converter_a_timing_ctrl_reg <= conv_cfg_pkg::REG_RESET;
      regulator_b_ctrl_reg        <= conv_cfg_pkg::REG_RESET;
      regulator_c_ctrl_reg        <= conv_cfg_pkg::REG_RESET;
      sequencing_ontime_ctrl_reg  <= conv_cfg_pkg::REG_RESET;
      buck_protect_ctrl_reg       <= conv_cfg_pkg::REG_RESET;
      buck_mode_ctrl_reg          <= conv_cfg_pkg::REG_RESET;
      env_ctrl_reg                <= conv_cfg_pkg::REG_RESET;
    end
    else
    begin
      if (wr_mode)  mode_reg                    <= wbyte;
      if (wr_badj)  boost_adjust_ctrl_reg       <= wbyte;
      if (wr_tim)   converter_a_timing_ctrl_reg <= wbyte;
      if (wr_regb)  regulator_b_ctrl_reg        <= wbyte;
      if (wr_regc)  regulator_c_ctrl_reg        <= wbyte;
      if (wr_seq)   sequencing_ontime_ctrl_reg  <= wbyte;
      // Reserved bits kept at zero
      if (wr_prot)  buck_protect_ctrl_reg <=
                      wbyte & conv_cfg_pkg::BUCK_PROT_MASK;
      if (wr_bmode) buck_mode_ctrl_reg          <= wbyte;
      if (wr_env)   env_ctrl_reg                <= wbyte;
    end
  end

  // Decoded outputs, one cycle behind the registers
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      conv_one_op_out                   <= conv_cfg_pkg::OP_OFF;
      conv_one_fallback_ldo_out         <= 1'b0;
      converter_one_predriver_speed_out <= 2'b00;
      boost_comp_active_out             <= 1'b0;
      boost_peak_comp_value_out         <= 6'h00;
      switched_output_highspeed_out     <= 1'b0;
      inrush_a_bounded_out              <= 1'b0;
      inrush_a_cycles_out               <= '0;
      offtime_bounded_out               <= 1'b0;
      offtime_cycles_out                <= '0;
      ontime_a_bounded_out              <= 1'b0;
      ontime_a_cycles_out               <= '0;
      inrush_c_bounded_out              <= 1'b0;
      inrush_c_cycles_out               <= '0;
      regulator_b_cfg_out               <= '0;
      regulator_c_cfg_out               <= '0;
      regulator_c_enable_out            <= 1'b0;
      buck_enable_allowed_out           <= 1'b0;
      buck_overvoltage_pulldown_out     <= 1'b0;
      buck_output_shutoff_pulldown_out  <= 1'b0;
      buck_ontime_bounded_out           <= 1'b0;
      buck_ontime_cycles_out            <= '0;
    end
    else
    begin
      conv_one_op_out           <= op_next;
      conv_one_fallback_ldo_out <= fallback_next;
      converter_one_predriver_speed_out <=
        boost_adjust_ctrl_reg[conv_cfg_pkg::SPEED_LSB +: 2];
      boost_comp_active_out     <= comp_next;
      // Value held at zero when compensation is off
      boost_peak_comp_value_out <= comp_next ?
        boost_adjust_ctrl_reg[conv_cfg_pkg::ADJ_LSB +: 6] : 6'h00;
      switched_output_highspeed_out <=
        converter_a_timing_ctrl_reg[conv_cfg_pkg::SWFAST_BIT];
      inrush_a_bounded_out      <= ia_bnd;
      inrush_a_cycles_out       <= ia_bnd ? ia_cyc : '0;
      // Off-time limit applies only in boost stages
      offtime_bounded_out       <= toff_bnd_next & boost_like;
      offtime_cycles_out        <= toff_next;
      ontime_a_bounded_out      <= ta_bnd;
      ontime_a_cycles_out       <= ta_bnd ? ta_cyc : '0;
      inrush_c_bounded_out      <= ic_bnd;
      inrush_c_cycles_out       <= ic_bnd ? ic_cyc : '0;
      regulator_b_cfg_out       <= regb_cfg;
      regulator_c_cfg_out       <= regc_cfg;
      regulator_c_enable_out    <= regc_next;
      buck_enable_allowed_out   <= buck_next;
      buck_overvoltage_pulldown_out    <= ovp_next;
      buck_output_shutoff_pulldown_out <= clamp_next;
      buck_ontime_bounded_out   <= tb_bnd;
      buck_ontime_cycles_out    <= tb_bnd ? tb_cyc : '0;
    end
  end

endmodule : regulator_converter_config_bank
`default_nettype wire

// >>> tb/conv_cfg_assertions.sv
// Port assertions for the config bank
`timescale 1ns/1ns
`default_nettype none
module conv_cfg_checker #(parameter int unsigned CYC_W = 12) (
  input wire logic             core_clk_in,
  input wire logic             sys_rst_in,
  input wire logic             avs_waitrequest_out,
  input wire logic [1:0]       energy_state_in,
  input wire logic [1:0]       conv_one_op_out,
  input wire logic             boost_comp_active_out,
  input wire logic [5:0]       boost_peak_comp_value_out,
  input wire logic             inrush_a_bounded_out,
  input wire logic [CYC_W-1:0] inrush_a_cycles_out,
  input wire logic             offtime_bounded_out,
  input wire logic             regulator_c_enable_out,
  input wire logic             buck_enable_allowed_out,
  input wire logic             buck_output_shutoff_pulldown_out,
  input wire conv_cfg_pkg::ldo_cfg_t regulator_b_cfg_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_ack_single: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out) else $error("ack long");
  a_comp_gated: assert property (
    !boost_comp_active_out |-> boost_peak_comp_value_out == 6'h00)
    else $error("comp leaks");
  a_low_power_comp: assert property (
    energy_state_in == 2'h1 |=> !boost_comp_active_out) else $error("comp");
  a_shutoff_off: assert property (
    energy_state_in == 2'h3 |=> conv_one_op_out == 2'h0
    && !regulator_c_enable_out && !buck_enable_allowed_out)
    else $error("shutoff");
  a_clamp_state: assert property (
    buck_output_shutoff_pulldown_out |-> $past(energy_state_in) == 2'h3)
    else $error("clamp");
  a_inrush_zero: assert property (
    !inrush_a_bounded_out |-> inrush_a_cycles_out == '0)
    else $error("inrush");
  a_offtime_boost: assert property (
    offtime_bounded_out |-> conv_one_op_out == 2'h2) else $error("offtime");
  a_gain_div: assert property (
    !$past(sys_rst_in) |-> regulator_b_cfg_out.gain_divisor ==
    5'h11 - regulator_b_cfg_out.current_gain) else $error("divisor");
  c_comp: cover property (boost_comp_active_out);
  c_clamp: cover property (buck_output_shutoff_pulldown_out);
  c_offtime: cover property (offtime_bounded_out);
endmodule : conv_cfg_checker
`default_nettype wire

// >>> tb/tb.sv
// Register-level test of the config bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic input_too_low_in = 1'b0;
  logic conv_one_in_regulation_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [1:0] energy_state_in = 2'h0;
  logic [31:0] avs_readdata_out, rdq;
  logic [1:0] conv_one_op_out, converter_one_predriver_speed_out;
  logic [5:0] boost_peak_comp_value_out;
  logic [11:0] inrush_a_cycles_out, offtime_cycles_out, ontime_a_cycles_out;
  logic [11:0] inrush_c_cycles_out, buck_ontime_cycles_out;
  conv_cfg_pkg::ldo_cfg_t regulator_b_cfg_out, regulator_c_cfg_out;
  logic avs_waitrequest_out, conv_one_fallback_ldo_out, boost_comp_active_out;
  logic switched_output_highspeed_out, inrush_a_bounded_out;
  logic offtime_bounded_out, ontime_a_bounded_out, inrush_c_bounded_out;
  logic regulator_c_enable_out, buck_enable_allowed_out;
  logic buck_overvoltage_pulldown_out, buck_output_shutoff_pulldown_out;
  logic buck_ontime_bounded_out;
  int miscompares = 0;
  int total_checks = 0;
  always #50 core_clk_in = ~core_clk_in;
  regulator_converter_config_bank uut (.*);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Opening edge wait leaves an idle cycle between requests
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h00_0000, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 20);
    rdq = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      finish_test();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdq, e);
  endtask : rdc
  task automatic settle();
    repeat (3) @(posedge core_clk_in);
  endtask : settle
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++)
      rdc(8'h50 + 8'(i), 32'h0000_0000);
    chk({inrush_a_bounded_out, ontime_a_bounded_out,
         inrush_c_bounded_out, buck_ontime_bounded_out}, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      // Mode 7 first, so standalone C is set here alongside mode 7; it stays set through the later mode 5 writes
      wr(8'h50 + 8'(i), 8'ha7 ^ 8'(i));
      rdc(8'h50 + 8'(i),
          (i == 6) ? 32'h0000_0001 : 32'h0000_00a7 ^ i);
    end
    rdc(8'h70, 32'h0000_0000);
    avs_byteenable_in <= 4'he;
    wr(8'h60, 8'h55);
    avs_byteenable_in <= 4'hf;
    rdc(8'h60, 32'h0000_0000);
    wr(8'h60, 8'h3c);
    rdc(8'h60, 32'h0000_003c);
    chk(converter_one_predriver_speed_out, 2'h2);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h50, 8'(m));
      settle();
      chk(conv_one_op_out, 16'h96d4 >> (2 * m) & 2'h3);
    end
    input_too_low_in <= 1'b1;
    wr(8'h50, 8'h05);
    settle();
    chk({conv_one_op_out, conv_one_fallback_ldo_out}, 3'h1);
    wr(8'h51, 8'h6a);
    wr(8'h52, 8'h3f);
    wr(8'h50, 8'h04);
    settle();
    chk(boost_comp_active_out, 1'b1);
    chk(boost_peak_comp_value_out, 6'h2a);
    chk({inrush_a_cycles_out, offtime_cycles_out}, 24'h05_d015);
    chk({inrush_a_bounded_out, offtime_bounded_out}, 2'h3);
    energy_state_in <= 2'h1;
    settle();
    chk(boost_comp_active_out, 1'b0);
    energy_state_in <= 2'h0;
    wr(8'h52, 8'hff);
    settle();
    chk(boost_comp_active_out, 1'b0);
    chk(switched_output_highspeed_out, 1'b1);
    wr(8'h55, 8'hf1);
    wr(8'h57, 8'h20);
    wr(8'h54, 8'h80);
    settle();
    chk(ontime_a_cycles_out, 12'h014);
    chk(inrush_c_cycles_out, 12'h009);
    chk(buck_ontime_cycles_out, 12'h003);
    chk({ontime_a_bounded_out, inrush_c_bounded_out,
         buck_ontime_bounded_out}, 3'h7);
    chk({buck_enable_allowed_out, regulator_c_enable_out}, 2'h0);
    conv_one_in_regulation_in <= 1'b1;
    settle();
    chk(buck_enable_allowed_out, 1'b1);
    chk(regulator_c_enable_out, 1'b1);
    wr(8'h61, 8'hff);
    rdc(8'h61, 32'h0000_0062);
    wr(8'h53, 8'hc5);
    wr(8'h54, 8'h4b);
    settle();
    chk(regulator_b_cfg_out, 13'h10ac);
    chk(regulator_c_cfg_out, 13'h1166);
    wr(8'h56, 8'h01);
    energy_state_in <= 2'h3;
    settle();
    chk(buck_overvoltage_pulldown_out, 1'b1);
    chk(buck_output_shutoff_pulldown_out, 1'b1);
    wr(8'h56, 8'h02);
    settle();
    chk(buck_overvoltage_pulldown_out, 1'b0);
    chk(buck_output_shutoff_pulldown_out, 1'b0);
    finish_test();
  end
endmodule : tb
bind regulator_converter_config_bank
  conv_cfg_checker #(.CYC_W(CYC_W)) chk_i (.*);
`default_nettype wire
